// [rtl/asp_pkg.sv]
package asp_pkg;
// What this block does
// R1: Enabled port owns tx out, rx in.
// R2: Idle enabled transmitter holds line high.
// R3: Any reset leaves the port disabled.
// R4: Disabled port returns pins to port control.
// R5: Disable empties buffers, resets baud counter.
// R6: Disable clears status flags, sets idle flags.
// R7: Disable keeps selects, config and divisor.
// R8: Disable aborts transfers in flight.
// R9: Re-enable resumes with retained configuration.
// R10: Alternate select one uses alternate pins.
// R11: Alternate select zero uses primary pins.
// R12: Full duplex, eight or nine data bits.
// R13: Eight bits: even, odd, none parity.
// R14: One or two stop bits.
// R15: Bit timing from 16-bit divisor.
// R16: Divisor zero gives clock over sixteen.
// R17: Four-word transmit and receive buffers.
// R18: Flag parity, framing and overrun errors.
// R19: Address mode interrupts on ninth bit.
// R20: Separate transmit and receive interrupts.
// R21: Loopback returns transmit to receiver.
// R22: Enable is bit 15 of config.
// R23: Reset format is 8N1.
// R24: Disabled port ignores receive line.

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
localparam int ASP_ADDR_W = 8;
localparam int ASP_DATA_W = 16;
localparam int ASP_FIFO_D = 4;
localparam logic [7:0] ASP_OFF_MODE = 8'h00;
localparam logic [7:0] ASP_OFF_STA = 8'h04;
localparam logic [7:0] ASP_OFF_TX = 8'h08;
localparam logic [7:0] ASP_OFF_RX = 8'h0C;
localparam logic [7:0] ASP_OFF_BRG = 8'h10;
localparam int ASP_MODE_EN = 15;
localparam int ASP_MODE_ALT = 10;
localparam int ASP_MODE_LOOP = 6;
localparam int ASP_MODE_PD = 1;
localparam int ASP_MODE_STOP = 0;
localparam int ASP_STA_TXISEL = 15;
localparam int ASP_STA_BRK = 11;
localparam int ASP_STA_TXEN = 10;
localparam int ASP_STA_RXISEL = 6;
localparam int ASP_STA_ADET = 5;
localparam int ASP_STA_OVR = 1;
localparam logic [15:0] ASP_MODE_RST = 16'h0000;
localparam logic [15:0] ASP_STA_RST = 16'h0000;
localparam logic [15:0] ASP_BRG_RST = 16'h0000;

// ----------------------------------------------------------------
// Encodings and timing
// ----------------------------------------------------------------
localparam logic [1:0] ASP_PD_8N = 2'h0;
localparam logic [1:0] ASP_PD_8E = 2'h1;
localparam logic [1:0] ASP_PD_8O = 2'h2;
localparam logic [1:0] ASP_PD_9N = 2'h3;
localparam logic [1:0] ASP_RXI_3 = 2'h2;
localparam logic [1:0] ASP_RXI_4 = 2'h3;
localparam int ASP_RXI_CNT3 = 3;
localparam logic [3:0] ASP_OS_LAST = 4'hF;
localparam logic [3:0] ASP_OS_MID = 4'h7;
localparam logic [3:0] ASP_BITS_BASE = 4'hA;

typedef enum logic [1:0] {
  ASP_RX_IDLE = 2'b00,
  ASP_RX_START = 2'b01,
  ASP_RX_DATA = 2'b10,
  ASP_RX_STOP = 2'b11
} asp_rxst_t;

typedef struct packed {
  logic parErr;
  logic frmErr;
  logic [8:0] data;
} asp_rxw_t;

typedef struct packed {
  logic [3:0] lat;
  logic [3:0] dir;
} asp_port_t;
endpackage

// [rtl/asp_uart.sv]
`timescale 1ns/1ps
`default_nettype none
module asp_uart #(
  parameter int FIFO_D = asp_pkg::ASP_FIFO_D
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [asp_pkg::ASP_ADDR_W-1:0] regAddr,
  input wire logic [asp_pkg::ASP_DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [asp_pkg::ASP_DATA_W-1:0] regRdata_ff,
  input wire asp_pkg::asp_port_t portCtl,
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut_ff,
  output logic [3:0] pinOe_ff,
  output logic txIrq_ff,
  output logic rxIrq_ff
);
  import asp_pkg::*;
  localparam int PW = $clog2(FIFO_D);
  localparam int CW = $clog2(FIFO_D + 1);
  localparam logic [CW-1:0] FULL = CW'(FIFO_D);

  function automatic logic wrHit(input logic w, input logic [ASP_ADDR_W-1:0] a,
                                 input logic [ASP_ADDR_W-1:0] off);
    wrHit = w && (a == off);
  endfunction

  function automatic logic [PW-1:0] incPtr(input logic [PW-1:0] p);
    incPtr = (p == PW'(FIFO_D - 1)) ? '0 : p + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic modeEn_ff, modeAlt_ff, modeLoop_ff, stsel_ff;
  logic [1:0] pdsel_ff;
  logic txisel_ff, brk_ff, txen_ff, addrDet_ff, ovrErr_ff;
  logic [1:0] rxisel_ff;
  logic [15:0] brg_ff;

  // Mode, divisor and selects are only touched by reset or software, so a disable
  // followed by an enable resumes with them; txen and brk come back cleared.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      modeEn_ff <= ASP_MODE_RST[ASP_MODE_EN]; // [R3]
      modeAlt_ff <= ASP_MODE_RST[ASP_MODE_ALT];
      modeLoop_ff <= ASP_MODE_RST[ASP_MODE_LOOP];
      pdsel_ff <= ASP_MODE_RST[ASP_MODE_PD +: 2]; // [R23]
      stsel_ff <= ASP_MODE_RST[ASP_MODE_STOP]; // [R23]
      brg_ff <= ASP_BRG_RST;
      txisel_ff <= ASP_STA_RST[ASP_STA_TXISEL];
      rxisel_ff <= ASP_STA_RST[ASP_STA_RXISEL +: 2];
      addrDet_ff <= ASP_STA_RST[ASP_STA_ADET];
      txen_ff <= ASP_STA_RST[ASP_STA_TXEN];
      brk_ff <= ASP_STA_RST[ASP_STA_BRK];
    end
    else if (ce)
    begin
      if (wrHit(regWr, regAddr, ASP_OFF_MODE))
      begin
        modeEn_ff <= regWdata[ASP_MODE_EN]; // [R22] [R9]
        modeAlt_ff <= regWdata[ASP_MODE_ALT];
        modeLoop_ff <= regWdata[ASP_MODE_LOOP];
        pdsel_ff <= regWdata[ASP_MODE_PD +: 2];
        stsel_ff <= regWdata[ASP_MODE_STOP];
      end
      if (wrHit(regWr, regAddr, ASP_OFF_BRG))
        brg_ff <= regWdata; // [R15]
      if (wrHit(regWr, regAddr, ASP_OFF_STA))
      begin
        txisel_ff <= regWdata[ASP_STA_TXISEL];
        rxisel_ff <= regWdata[ASP_STA_RXISEL +: 2];
        addrDet_ff <= regWdata[ASP_STA_ADET];
        txen_ff <= regWdata[ASP_STA_TXEN];
        brk_ff <= regWdata[ASP_STA_BRK];
      end
      if (!modeEn_ff)
      begin
        txen_ff <= 1'b0; // [R6] [R7]
        brk_ff <= 1'b0; // [R6]
      end
    end
  end

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  logic [15:0] baudCnt_ff;
  logic tick;
  // A divisor lowered while running must not leave the counter above it for a full wrap.
  assign tick = modeEn_ff && (baudCnt_ff >= brg_ff); // [R15] [R16]

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || (ce && !modeEn_ff))
      baudCnt_ff <= '0; // [R5]
    else if (ce)
      baudCnt_ff <= tick ? '0 : baudCnt_ff + 1'b1;
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [8:0] txMem [FIFO_D];
  logic [PW-1:0] txWp_ff, txRp_ff;
  logic [CW-1:0] txCnt_ff;
  logic [12:0] txSh_ff;
  logic [3:0] txBits_ff, txPh_ff, txLen;
  logic [8:0] txHead;
  logic txPush, txPop, txPar, txNinth, txLine;

  assign txHead = txMem[txRp_ff];
  // A write to a full buffer is dropped and leaves the buffer untouched.
  assign txPush = wrHit(regWr, regAddr, ASP_OFF_TX) && (txCnt_ff != FULL); // [R17]
  assign txPop = txen_ff && !brk_ff && (txBits_ff == '0) && (txCnt_ff != '0);
  assign txPar = (^txHead[7:0]) ^ (pdsel_ff == ASP_PD_8O); // [R13]
  assign txNinth = (pdsel_ff == ASP_PD_9N) ? txHead[8] :
                   ((pdsel_ff == ASP_PD_8N) ? 1'b1 : txPar); // [R12] [R13]
  assign txLen = ASP_BITS_BASE + {3'b000, pdsel_ff != ASP_PD_8N}
                 + {3'b000, stsel_ff}; // [R14]
  // The shifter refills with ones, so an idle line rests high.
  assign txLine = brk_ff ? 1'b0 : txSh_ff[0]; // [R2]

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || (ce && !modeEn_ff))
    begin
      txWp_ff <= '0; // [R5] [R8]
      txRp_ff <= '0;
      txCnt_ff <= '0;
      txBits_ff <= '0;
      txPh_ff <= '0;
      txSh_ff <= '1;
    end
    else if (ce)
    begin
      if (txPush)
      begin
        txMem[txWp_ff] <= regWdata[8:0];
        txWp_ff <= incPtr(txWp_ff);
      end
      if (txPop)
      begin
        txRp_ff <= incPtr(txRp_ff);
        txSh_ff <= {3'b111, txNinth, txHead[7:0], 1'b0};
        txBits_ff <= txLen;
        txPh_ff <= '0;
      end
      else if (tick && (txBits_ff != '0))
      begin
        txPh_ff <= txPh_ff + 1'b1;
        if (txPh_ff == ASP_OS_LAST)
        begin
          txSh_ff <= {1'b1, txSh_ff[12:1]};
          txBits_ff <= txBits_ff - 1'b1;
        end
      end
      txCnt_ff <= txCnt_ff + CW'(txPush) - CW'(txPop);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      txIrq_ff <= 1'b0;
    else if (ce)
      txIrq_ff <= txPop && (!txisel_ff || (txCnt_ff == CW'(1) && !txPush)); // [R20]
  end

  // ----------------------------------------------------------------
  // Receive pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rxRaw, rxS1_ff, rxS2_ff, rxS3_ff, rxLvl_ff;
  assign rxRaw = {pinIn[3], pinIn[1]};

  for (genvar j = 0; j < 2; j++)
  begin : g_sync
    always_ff @(posedge sys_clk)
    begin
      if (!rst_b)
      begin
        rxS1_ff[j] <= 1'b1;
        rxS2_ff[j] <= 1'b1;
        rxS3_ff[j] <= 1'b1;
        rxLvl_ff[j] <= 1'b1;
      end
      else if (ce)
      begin
        rxS1_ff[j] <= rxRaw[j];
        rxS2_ff[j] <= rxS1_ff[j];
        rxS3_ff[j] <= rxS2_ff[j];
        if (rxS2_ff[j] == rxS3_ff[j])
          rxLvl_ff[j] <= rxS3_ff[j];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  asp_rxst_t rxSt_ff;
  asp_rxw_t rxMem [FIFO_D];
  asp_rxw_t rxWord, rxHead;
  logic [PW-1:0] rxWp_ff, rxRp_ff;
  logic [CW-1:0] rxCnt_ff, rxNewCnt;
  logic [9:0] rxSh_ff;
  logic [3:0] rxPh_ff, rxBits_ff, rxLastBit;
  logic rxFrmErr_ff, rxIn, rxDone, rxPush, rxPop, rxSel;

  // Loopback keeps the pins under port rules but feeds the receiver.
  assign rxIn = modeLoop_ff ? txLine : (modeAlt_ff ? rxLvl_ff[1] : rxLvl_ff[0]); // [R21] [R10] [R11]
  assign rxLastBit = (pdsel_ff == ASP_PD_8N) ? 4'h7 : 4'h8; // [R12]
  assign rxDone = (rxSt_ff == ASP_RX_STOP) && tick && (rxPh_ff == ASP_OS_LAST)
                  && (rxBits_ff == {3'b000, stsel_ff}); // [R14]
  assign rxPush = rxDone && (rxCnt_ff != FULL);
  assign rxPop = wrHit(regRd, regAddr, ASP_OFF_RX) && (rxCnt_ff != '0);
  assign rxNewCnt = rxCnt_ff + CW'(1) - CW'(rxPop);
  assign rxHead = rxMem[rxRp_ff];

  always_comb
  begin
    rxWord.data = {1'b0, rxSh_ff[8:1]};
    if (pdsel_ff == ASP_PD_9N)
      rxWord.data = rxSh_ff[9:1];
    else if (pdsel_ff == ASP_PD_8N)
      rxWord.data = {1'b0, rxSh_ff[9:2]};
    rxWord.parErr = (pdsel_ff == ASP_PD_8E || pdsel_ff == ASP_PD_8O)
                    && (((^rxSh_ff[8:1]) ^ (pdsel_ff == ASP_PD_8O)) != rxSh_ff[9]); // [R18]
    rxWord.frmErr = rxFrmErr_ff || !rxIn; // [R18]
  end

  // Disable drops any frame in flight; a start is only hunted while enabled.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || (ce && !modeEn_ff))
    begin
      rxSt_ff <= ASP_RX_IDLE; // [R8] [R24]
      rxPh_ff <= '0;
      rxBits_ff <= '0;
      rxSh_ff <= '0;
      rxFrmErr_ff <= 1'b0;
    end
    else if (ce)
    begin
      case (rxSt_ff)
        ASP_RX_IDLE:
          if (!rxIn && !ovrErr_ff)
          begin
            rxSt_ff <= ASP_RX_START;
            rxPh_ff <= '0;
          end
        ASP_RX_START:
          if (tick)
          begin
            rxPh_ff <= rxPh_ff + 1'b1;
            if (rxPh_ff == ASP_OS_MID)
            begin
              rxSt_ff <= rxIn ? ASP_RX_IDLE : ASP_RX_DATA;
              rxPh_ff <= '0;
              rxBits_ff <= '0;
              rxSh_ff <= '0;
            end
          end
        ASP_RX_DATA:
          if (tick)
          begin
            rxPh_ff <= rxPh_ff + 1'b1;
            if (rxPh_ff == ASP_OS_LAST)
            begin
              rxSh_ff <= {rxIn, rxSh_ff[9:1]};
              rxBits_ff <= rxBits_ff + 1'b1;
              if (rxBits_ff == rxLastBit)
              begin
                rxSt_ff <= ASP_RX_STOP;
                rxBits_ff <= '0;
                rxFrmErr_ff <= 1'b0;
              end
            end
          end
        ASP_RX_STOP:
          if (tick)
          begin
            rxPh_ff <= rxPh_ff + 1'b1;
            if (rxPh_ff == ASP_OS_LAST)
            begin
              rxFrmErr_ff <= rxFrmErr_ff || !rxIn; // [R14]
              rxBits_ff <= rxBits_ff + 1'b1;
              if (rxDone)
                rxSt_ff <= ASP_RX_IDLE;
            end
          end
        default:
          rxSt_ff <= ASP_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || (ce && !modeEn_ff))
    begin
      rxWp_ff <= '0; // [R5]
      rxRp_ff <= '0;
      rxCnt_ff <= '0;
    end
    else if (ce)
    begin
      if (rxPush)
      begin
        rxMem[rxWp_ff] <= rxWord; // [R17]
        rxWp_ff <= incPtr(rxWp_ff);
      end
      if (rxPop)
        rxRp_ff <= incPtr(rxRp_ff);
      rxCnt_ff <= rxCnt_ff + CW'(rxPush) - CW'(rxPop);
    end
  end

  // A frame arriving while the buffer is full sets overrun; that set
  // beats a software clear in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || (ce && !modeEn_ff))
      ovrErr_ff <= 1'b0; // [R6]
    else if (ce)
    begin
      if (rxDone && (rxCnt_ff == FULL))
        ovrErr_ff <= 1'b1; // [R18]
      else if (wrHit(regWr, regAddr, ASP_OFF_STA) && !regWdata[ASP_STA_OVR])
        ovrErr_ff <= 1'b0;
    end
  end

  always_comb
  begin
    case (rxisel_ff)
      ASP_RXI_3: rxSel = (rxNewCnt == CW'(ASP_RXI_CNT3));
      ASP_RXI_4: rxSel = (rxNewCnt == FULL);
      default: rxSel = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      rxIrq_ff <= 1'b0;
    else if (ce)
      rxIrq_ff <= rxPush && rxSel
                  && (!addrDet_ff || pdsel_ff != ASP_PD_9N || rxWord.data[8]); // [R19] [R20]
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      regRdata_ff <= '0;
    else if (ce)
    begin
      regRdata_ff <= '0;
      if (regRd)
        case (regAddr)
          ASP_OFF_MODE: regRdata_ff <= {modeEn_ff, 4'h0, modeAlt_ff, 3'b000,
                                        modeLoop_ff, 3'b000, pdsel_ff, stsel_ff};
          ASP_OFF_STA: regRdata_ff <= {txisel_ff, 3'b000, brk_ff, txen_ff,
                                       txCnt_ff == FULL, txBits_ff == '0 && txCnt_ff == '0,
                                       rxisel_ff, addrDet_ff, rxSt_ff == ASP_RX_IDLE,
                                       rxHead.parErr && rxCnt_ff != '0,
                                       rxHead.frmErr && rxCnt_ff != '0,
                                       ovrErr_ff, rxCnt_ff != '0}; // [R6]
          ASP_OFF_RX: regRdata_ff <= {7'h00, rxHead.data};
          ASP_OFF_BRG: regRdata_ff <= brg_ff;
          default: regRdata_ff <= '0;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership: 0 primary tx, 1 primary rx, 2 alternate tx, 3 alternate rx
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    always_ff @(posedge sys_clk)
    begin
      if (!rst_b)
      begin
        pinOut_ff[i] <= 1'b0;
        pinOe_ff[i] <= 1'b0;
      end
      else if (ce)
      begin
        if (modeEn_ff && (modeAlt_ff == (i >= 2)))
        begin
          pinOut_ff[i] <= (i % 2 == 0) ? txLine : 1'b0; // [R1] [R10] [R11]
          pinOe_ff[i] <= (i % 2 == 0); // [R1]
        end
        else
        begin
          pinOut_ff[i] <= portCtl.lat[i]; // [R4]
          pinOe_ff[i] <= !portCtl.dir[i]; // [R4]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_idle_high: // [R2]
    assert property ((txBits_ff == '0 && !brk_ff) |-> txLine)
      else $error("idle transmit line not high");
  a_pin_prim: // [R1]
    assert property ((ce && modeEn_ff && !modeAlt_ff)
      |=> (pinOe_ff[0] && !pinOe_ff[1] && pinOut_ff[0] == $past(txLine)))
      else $error("primary pins not owned");
  a_pin_alt: // [R10]
    assert property ((ce && modeEn_ff && modeAlt_ff)
      |=> (pinOe_ff[2] && !pinOe_ff[3] && pinOe_ff[0] == !$past(portCtl.dir[0])))
      else $error("alternate pins not owned");
  a_pin_release: // [R4]
    assert property ((rst_b && ce && !modeEn_ff)
      |=> (pinOut_ff == $past(portCtl.lat) && pinOe_ff == ~$past(portCtl.dir)))
      else $error("pins not released to port");
  a_disable_flush: // [R6]
    assert property ((ce && !modeEn_ff) |=> (txCnt_ff == '0 && rxCnt_ff == '0
      && !ovrErr_ff && !txen_ff && rxSt_ff == ASP_RX_IDLE && txBits_ff == '0))
      else $error("disable did not flush");
  a_reset_off: // [R3]
    assert property ($rose(rst_b) |-> (!modeEn_ff && pdsel_ff == ASP_PD_8N && !stsel_ff))
      else $error("reset left port enabled");
  a_tx_full_drop: // [R17]
    assert property ((ce && modeEn_ff && wrHit(regWr, regAddr, ASP_OFF_TX)
      && txCnt_ff == FULL && !txPop) |=> (txCnt_ff == FULL && $stable(txWp_ff)))
      else $error("write to full buffer accepted");
  a_rx_overrun: // [R18]
    assert property ((ce && rxDone && rxCnt_ff == FULL) |=> (ovrErr_ff && rxCnt_ff == FULL))
      else $error("overrun not flagged");
endmodule
`default_nettype wire

// [sim/asp_remote.sv]
`timescale 1ns/1ps
`default_nettype none
module asp_remote
  import asp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic txLine,
  input wire logic [19:0] bitCyc,
  input wire logic [1:0] fmt,
  input wire logic stop2,
  input wire logic badPar,
  input wire logic badStop,
  output logic rxLine
);
  logic [10:0] gotQ[$];

  initial rxLine = 1'b1;

  function automatic logic par(input logic [8:0] d);
    return (^d[7:0]) ^ (fmt == ASP_PD_8O);
  endfunction

  // ----------------------------------------------------------------
  // Sender; the bad parity and bad stop inputs break the frame on purpose.
  // ----------------------------------------------------------------
  task automatic send(input logic [8:0] d);
    int n;
    n = (fmt == ASP_PD_9N) ? 9 : 8;
    rxLine <= 1'b0;
    repeat (bitCyc) @(posedge sys_clk);
    for (int i = 0; i < n; i++)
    begin
      rxLine <= d[i];
      repeat (bitCyc) @(posedge sys_clk);
    end
    if (fmt == ASP_PD_8E || fmt == ASP_PD_8O)
    begin
      rxLine <= par(d) ^ badPar;
      repeat (bitCyc) @(posedge sys_clk);
    end
    rxLine <= ~badStop;
    repeat (stop2 ? 2 * bitCyc : bitCyc) @(posedge sys_clk);
    rxLine <= 1'b1;
    repeat (bitCyc) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Receiver; samples mid-bit so it never races the launching edge.
  // ----------------------------------------------------------------
  always
  begin : rx_proc
    logic [8:0] d;
    logic pe;
    logic fe;
    @(negedge txLine);
    d = 9'h000;
    pe = 1'b0;
    repeat (bitCyc / 2) @(posedge sys_clk);
    for (int i = 0; i < ((fmt == ASP_PD_9N) ? 9 : 8); i++)
    begin
      repeat (bitCyc) @(posedge sys_clk);
      d[i] = txLine;
    end
    if (fmt == ASP_PD_8E || fmt == ASP_PD_8O)
    begin
      repeat (bitCyc) @(posedge sys_clk);
      pe = (txLine !== par(d));
    end
    repeat (bitCyc) @(posedge sys_clk);
    fe = (txLine !== 1'b1);
    if (stop2)
    begin
      repeat (bitCyc) @(posedge sys_clk);
      fe = fe | (txLine !== 1'b1);
    end
    gotQ.push_back({fe, pe, d});
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, gt); end end
module testbench;
  import asp_pkg::*;
  typedef struct packed {logic [1:0] fmt; logic stop2; logic [8:0] d;} asp_row_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata_ff;
  asp_port_t portCtl = '{lat: 4'b1101, dir: 4'b0000};
  logic [3:0] pinIn;
  logic [3:0] pinOut;
  logic [3:0] pinOe;
  logic txIrq;
  logic rxIrq;
  logic altSel = 1'b0;
  logic [19:0] bitCyc = 20'h0_0010;
  logic [1:0] fmt = 2'h0;
  logic stop2 = 1'b0;
  logic badPar = 1'b0;
  logic badStop = 1'b0;
  logic rxLine;
  logic txLine;
  logic [15:0] rdat;
  logic [10:0] got;
  int n_mismatch = 0;
  int check_count = 0;
  int txIrqCnt = 0;
  int rxIrqCnt = 0;
  int n;
  asp_row_t rows [4] = '{'{ASP_PD_8N, 1'b1, 9'h0A5}, '{ASP_PD_8E, 1'b0, 9'h0C3},
                         '{ASP_PD_8O, 1'b1, 9'h07E}, '{ASP_PD_9N, 1'b0, 9'h1A5}};

  always #2 sys_clk = ~sys_clk;

  // Released lines are pulled up, so an undriven pin reads high.
  assign pinIn = {altSel ? rxLine : 1'b1, 1'b1, altSel ? 1'b1 : rxLine, 1'b1};
  assign txLine = altSel ? (pinOe[2] ? pinOut[2] : 1'b1) : (pinOe[0] ? pinOut[0] : 1'b1);

  always @(posedge sys_clk)
  begin
    if (txIrq === 1'b1) txIrqCnt++;
    if (rxIrq === 1'b1) rxIrqCnt++;
  end

  asp_uart DUT (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_ff(regRdata_ff),
    .portCtl(portCtl), .pinIn(pinIn), .pinOut_ff(pinOut), .pinOe_ff(pinOe),
    .txIrq_ff(txIrq), .rxIrq_ff(rxIrq));

  asp_remote remote (.sys_clk(sys_clk), .txLine(txLine), .bitCyc(bitCyc), .fmt(fmt),
    .stop2(stop2), .badPar(badPar), .badStop(badStop), .rxLine(rxLine));

  // ----------------------------------------------------------------
  // Bus and wait helpers
  // ----------------------------------------------------------------
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task tmo();
    n_mismatch++;
    $display("unexpected timeout: expected %0d seen %0d", 1, 0);
    end_of_test();
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata_ff;
  endtask

  task chkrd(input string nm, input logic [7:0] a, input logic [15:0] e);
    rd(a, rdat);
    `CHK(nm, e, rdat)
  endtask

  task automatic pollSta(input logic [15:0] m);
    int i;
    i = 0;
    rd(ASP_OFF_STA, rdat);
    while ((rdat & m) === 16'h0000 && i < 100)
    begin
      rd(ASP_OFF_STA, rdat);
      i++;
    end
    if ((rdat & m) === 16'h0000) tmo();
  endtask

  task automatic waitq();
    int i;
    i = 0;
    while (remote.gotQ.size() == 0 && i < 4000)
    begin
      @(posedge sys_clk);
      i++;
    end
    if (remote.gotQ.size() == 0) tmo();
    got = remote.gotQ.pop_front();
  endtask

  task endt(input string s);
    $display("test %s finished", s);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      fmt <= rows[k].fmt;
      stop2 <= rows[k].stop2;
      wr(ASP_OFF_MODE, {1'b1, 12'h000, rows[k].fmt, rows[k].stop2});
      wr(ASP_OFF_STA, 16'h0400);
      `CHK("txIdle", 1'b1, pinOut[0])
      `CHK("pinOeOn", 4'hD, pinOe)
      n = txIrqCnt;
      wr(ASP_OFF_TX, {7'h00, rows[k].d});
      waitq();
      `CHK("wireWord", {2'b00, rows[k].d}, got)
      `CHK("txIrq", n + 1, txIrqCnt)
      remote.send(rows[k].d);
      pollSta(16'h0001);
      chkrd("rxSta", ASP_OFF_STA, 16'h0511);
      chkrd("rxWord", ASP_OFF_RX, {7'h00, rows[k].d});
      `CHK("rxIrq", k + 1, rxIrqCnt)
      endt("format row");
    end
    fmt <= ASP_PD_8E;
    stop2 <= 1'b0;
    wr(ASP_OFF_MODE, 16'h8002);
    badPar <= 1'b1;
    remote.send(9'h0F0);
    badPar <= 1'b0;
    badStop <= 1'b1;
    remote.send(9'h00F);
    badStop <= 1'b0;
    pollSta(16'h0001);
    chkrd("perrSta", ASP_OFF_STA, 16'h0519);
    rd(ASP_OFF_RX, rdat);
    chkrd("ferrSta", ASP_OFF_STA, 16'h0515);
    rd(ASP_OFF_RX, rdat);
    endt("errors");
    fmt <= ASP_PD_8N;
    wr(ASP_OFF_MODE, 16'h8000);
    wr(ASP_OFF_STA, 16'h04C0);
    n = rxIrqCnt;
    for (int j = 0; j < 5; j++) remote.send(9'h010 + 9'(j));
    pollSta(16'h0002);
    `CHK("fullIrq", n + 1, rxIrqCnt)
    chkrd("ovrSta", ASP_OFF_STA, 16'h05D3);
    endt("overrun");
    // Disable in mid-frame with a full receive buffer and overrun pending.
    wr(ASP_OFF_TX, 16'h003C);
    repeat (60) @(posedge sys_clk);
    wr(ASP_OFF_MODE, 16'h0001);
    repeat (2) @(posedge sys_clk);
    `CHK("pinOeOff", 4'hF, pinOe)
    `CHK("pinOutOff", 4'hD, pinOut)
    chkrd("offSta", ASP_OFF_STA, 16'h01D0);
    chkrd("offMode", ASP_OFF_MODE, 16'h0001);
    wr(ASP_OFF_BRG, 16'h0001);
    bitCyc <= 20'h0_0020;
    remote.send(9'h0AA);
    repeat (200) @(posedge sys_clk);
    remote.gotQ.delete();
    stop2 <= 1'b1;
    wr(ASP_OFF_MODE, 16'h8001);
    wr(ASP_OFF_STA, 16'h0400);
    chkrd("onSta", ASP_OFF_STA, 16'h0510);
    chkrd("brgKept", ASP_OFF_BRG, 16'h0001);
    wr(ASP_OFF_TX, 16'h00C5);
    waitq();
    `CHK("reWord", 11'h0C5, got)
    endt("disable");
    bitCyc <= 20'h0_0010;
    stop2 <= 1'b0;
    wr(ASP_OFF_BRG, 16'h0000);
    altSel <= 1'b1;
    wr(ASP_OFF_MODE, 16'h8400);
    repeat (2) @(posedge sys_clk);
    `CHK("pinOeAlt", 4'h7, pinOe)
    wr(ASP_OFF_TX, 16'h005A);
    waitq();
    `CHK("altWord", 11'h05A, got)
    remote.send(9'h033);
    pollSta(16'h0001);
    chkrd("altRx", ASP_OFF_RX, 16'h0033);
    altSel <= 1'b0;
    endt("alternate pins");
    wr(ASP_OFF_MODE, 16'h8040);
    wr(ASP_OFF_TX, 16'h0069);
    pollSta(16'h0001);
    chkrd("loopRx", ASP_OFF_RX, 16'h0069);
    endt("loopback");
    // Sending stays off while the transmit buffer fills, so the fifth word must be dropped.
    fmt <= ASP_PD_9N;
    wr(ASP_OFF_MODE, 16'h8006);
    wr(ASP_OFF_STA, 16'h0020);
    for (int j = 0; j < 5; j++) wr(ASP_OFF_TX, 16'h0180 + 16'(j));
    chkrd("fullSta", ASP_OFF_STA, 16'h0230);
    n = rxIrqCnt;
    remote.send(9'h055);
    remote.send(9'h1AA);
    pollSta(16'h0001);
    `CHK("addrIrq", n + 1, rxIrqCnt)
    chkrd("addrRx0", ASP_OFF_RX, 16'h0055);
    chkrd("addrRx1", ASP_OFF_RX, 16'h01AA);
    remote.gotQ.delete();
    n = txIrqCnt;
    wr(ASP_OFF_STA, 16'h8420);
    for (int j = 0; j < 4; j++)
    begin
      waitq();
      `CHK("fifoWord", {2'b00, 9'h180 + 9'(j)}, got)
    end
    `CHK("txIrqSel", n + 1, txIrqCnt)
    endt("buffer and address detect");
    wr(ASP_OFF_MODE, 16'h8400);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("rstOe", 4'hF, pinOe)
    chkrd("rstMode", ASP_OFF_MODE, 16'h0000);
    chkrd("rstSta", ASP_OFF_STA, 16'h0110);
    chkrd("rstBrg", ASP_OFF_BRG, 16'h0000);
    endt("reset");
    end_of_test();
  end
endmodule
`default_nettype wire
